// *** hdl/cit_top.sv ***
// Interrupt code, flag register and time stamp unit of the CAN FD controller
// What this block does
// - Time base counts once every prescale plus one clocks while enabled.
// - Clearing the enable stops the time base and zeroes it.
// - Writing the counter restarts the prescaler count, prescale setting kept.
// - End-of-frame mode stamps when the received or sent frame becomes valid.
// - Otherwise stamp at start of frame, FD optionally at bit after FDF.
// - Counter wrap sets a sticky flag until software clears it.
// - Receive code gives highest pending receive FIFO, or 40h when idle.
// - Transmit code gives highest FIFO, queue as zero, or 40h when idle.
// - Filter match field reports the number of the matching filter.
// - Every code field reports the highest-numbered pending source.
// - Global codes 4Ah down to 46h for attempt, event FIFO, invalid, mode, wrap.
// - Global codes 45h down to 40h for buffer, address, overflow, wake, bus, none.
// - Global code reports pending FIFO number, transmit queue as zero.
// - Enable bits sit in 31..24 and 20..16 in fixed order.
// - Flags sit sixteen bits below their enables; gaps read zero.
// - Hardware sets the sticky flags; only a software write clears them.
// - Summary status flags are read-only and follow their pending condition.
// - Any change of reported operating mode sets the mode change flag.
// - Receive and transmit summary flags follow any pending FIFO interrupt.
// - Event FIFO flag follows the event FIFO interrupt condition.
// - Per-FIFO receive pending is its flag gated by its enable.
// - Transmit pending bit 0 is the queue, bits 1..31 the FIFOs.
`timescale 1ns/1ps
`include "cit_defs.svh"
module cit_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic invalid_msg_evt,
    input wire logic wake_evt,
    input wire logic bus_error_evt,
    input wire logic mab_error_evt,
    input wire logic addr_error_evt,
    input wire logic [2:0] operating_mode_status,
    input wire logic [31:0] rx_ovf_pending,
    input wire logic [31:0] tx_attempt_pending,
    input wire logic spi_check_pending,
    input wire logic ram_correction_pending,
    input wire logic tef_pending,
    input wire logic [31:0] rx_fifo_flags,
    input wire logic [31:0] rx_fifo_enables,
    input wire logic [31:0] tx_fifo_flags,
    input wire logic [31:0] tx_fifo_enables,
    input wire logic filter_match_evt,
    input wire logic [4:0] filter_match_in,
    input wire logic sof_sample,
    input wire logic fdf_next_sample,
    input wire logic rx_frame_ok,
    input wire logic tx_frame_ok,
    output logic [31:0] stamp_value,
    output logic stamp_strobe,
    output logic irq_n
);
    cit_tb_if tb_link ();

    cit_tbase u_tbase (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tb(tb_link.tbase)
    );

    // Control registers
    logic tb_enable_r;
    logic stamp_at_frame_end_r;
    logic fd_stamp_after_fdf_r;
    cit_pkg::cit_pre_type time_base_prescale_r;
    logic [7:0] en_hi_r;
    logic [4:0] en_lo_r;

    // Sticky flags
    logic invalid_msg_flag_r;
    logic wake_flag_r;
    logic bus_error_flag_r;
    logic system_error_flag_r;
    logic mab_cause_r;
    logic addr_cause_r;
    logic mode_change_flag_r;
    logic time_base_wrap_flag_r;
    logic [2:0] mode_prev_r;
    logic mode_primed_r;
    logic [4:0] filter_match_number_r;

    // Decode
    wire logic wr_tbc = reg_wr && reg_addr == `CIT_ADDR_TBC;
    wire logic wr_tsc = reg_wr && reg_addr == `CIT_ADDR_TSC;
    wire logic wr_int = reg_wr && reg_addr == `CIT_ADDR_INT;

    // Per-FIFO pending vectors
    wire logic [31:0] rx_fifo_pending_vector =
        {rx_fifo_flags[31:1] & rx_fifo_enables[31:1], 1'b0};
    wire logic [31:0] tx_fifo_pending_vector =
        tx_fifo_flags & tx_fifo_enables;

    // Read-only summary flags
    wire logic rx_overflow_flag = |rx_ovf_pending[31:1];
    wire logic tx_attempt_flag = |tx_attempt_pending;
    wire logic spi_check_flag = spi_check_pending;
    wire logic ram_correction_flag = ram_correction_pending;
    wire logic tx_event_fifo_flag = tef_pending;
    wire logic rx_summary_flag = |rx_fifo_pending_vector;
    wire logic tx_summary_flag = |tx_fifo_pending_vector;

    // Enable fields, top down
    wire logic invalid_msg_enable = en_hi_r[7];
    wire logic wake_enable = en_hi_r[6];
    wire logic bus_error_enable = en_hi_r[5];
    wire logic system_error_enable = en_hi_r[4];
    wire logic rx_overflow_enable = en_hi_r[3];
    wire logic tx_attempt_enable = en_hi_r[2];
    wire logic tx_event_fifo_enable = en_lo_r[4];
    wire logic mode_change_enable = en_lo_r[3];
    wire logic time_base_wrap_enable = en_lo_r[2];
    wire logic rx_summary_enable = en_lo_r[1];
    wire logic tx_summary_enable = en_lo_r[0];

    wire logic [7:0] flag_hi = {invalid_msg_flag_r, wake_flag_r, bus_error_flag_r,
        system_error_flag_r, rx_overflow_flag, tx_attempt_flag, spi_check_flag,
        ram_correction_flag};
    wire logic [4:0] flag_lo = {tx_event_fifo_flag, mode_change_flag_r,
        time_base_wrap_flag_r, rx_summary_flag, tx_summary_flag};
    wire logic [31:0] int_word = {en_hi_r, 3'b000, en_lo_r,
        flag_hi, 3'b000, flag_lo};
    wire logic any_enabled = |((int_word >> `CIT_EN_SHIFT) & int_word);

    // Codes
    wire cit_pkg::cit_code_type receive_code =
        cit_pkg::cit_high_code(rx_fifo_pending_vector);
    wire cit_pkg::cit_code_type transmit_code =
        cit_pkg::cit_high_code(tx_fifo_pending_vector);
    wire logic [31:0] fifo_irq_vec =
        ({32{rx_summary_enable}} & rx_fifo_pending_vector)
        | ({32{tx_summary_enable}} & tx_fifo_pending_vector);
    wire cit_pkg::cit_code_type fifo_code = cit_pkg::cit_high_code(fifo_irq_vec);
    // Highest number first, so the chain order is the priority
    wire cit_pkg::cit_code_type global_irq_code =
        (tx_attempt_flag && tx_attempt_enable) ? `CIT_CODE_TXAT :
        (tx_event_fifo_flag && tx_event_fifo_enable) ? `CIT_CODE_TEF :
        (invalid_msg_flag_r && invalid_msg_enable) ? `CIT_CODE_IVM :
        (mode_change_flag_r && mode_change_enable) ? `CIT_CODE_MOD :
        (time_base_wrap_flag_r && time_base_wrap_enable) ? `CIT_CODE_TBC :
        (mab_cause_r && system_error_enable) ? `CIT_CODE_MAB :
        (addr_cause_r && system_error_enable) ? `CIT_CODE_ADDR :
        (rx_overflow_flag && rx_overflow_enable) ? `CIT_CODE_RXOV :
        (wake_flag_r && wake_enable) ? `CIT_CODE_WAK :
        (bus_error_flag_r && bus_error_enable) ? `CIT_CODE_CERR :
        fifo_code;

    wire logic [31:0] vec_word = {1'b0, receive_code, 1'b0, transmit_code,
        3'b000, filter_match_number_r, 1'b0, global_irq_code};
    wire logic [31:0] tsc_word = {13'h0000, fd_stamp_after_fdf_r,
        stamp_at_frame_end_r, tb_enable_r, 6'h00, time_base_prescale_r};

    // Unmapped offsets read zero, so a stray probe sees nothing
    wire logic [31:0] rd_mux =
        (reg_addr == `CIT_ADDR_TBC) ? tb_link.count :
        (reg_addr == `CIT_ADDR_TSC) ? tsc_word :
        (reg_addr == `CIT_ADDR_VEC) ? vec_word :
        (reg_addr == `CIT_ADDR_INT) ? int_word :
        (reg_addr == `CIT_ADDR_RXV) ? rx_fifo_pending_vector :
        (reg_addr == `CIT_ADDR_TXV) ? tx_fifo_pending_vector :
        `CIT_ZERO32;

    // Time base link
    assign tb_link.enable = tb_enable_r;
    assign tb_link.prescale = time_base_prescale_r;
    assign tb_link.load = wr_tbc;
    assign tb_link.load_value = reg_wdata;

    // Sticky flag next values: a set in the clearing cycle survives
    wire logic clr_ok_ivm = !wr_int || reg_wdata[15];
    wire logic clr_ok_wak = !wr_int || reg_wdata[14];
    wire logic clr_ok_cerr = !wr_int || reg_wdata[13];
    wire logic clr_ok_serr = !wr_int || reg_wdata[12];
    wire logic clr_ok_mod = !wr_int || reg_wdata[3];
    wire logic clr_ok_tbc = !wr_int || reg_wdata[2];
    wire logic mode_evt = mode_primed_r && operating_mode_status != mode_prev_r;
    wire logic invalid_msg_flag_nxt = invalid_msg_evt || (invalid_msg_flag_r && clr_ok_ivm);
    wire logic wake_flag_nxt = wake_evt || (wake_flag_r && clr_ok_wak);
    wire logic bus_error_flag_nxt = bus_error_evt || (bus_error_flag_r && clr_ok_cerr);
    wire logic mab_cause_nxt = mab_error_evt || (mab_cause_r && clr_ok_serr);
    wire logic addr_cause_nxt = addr_error_evt || (addr_cause_r && clr_ok_serr);
    wire logic mode_change_flag_nxt = mode_evt || (mode_change_flag_r && clr_ok_mod);
    wire logic time_base_wrap_flag_nxt =
        tb_link.wrap || (time_base_wrap_flag_r && clr_ok_tbc);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_enable_r <= 1'b0;
            stamp_at_frame_end_r <= 1'b0;
            fd_stamp_after_fdf_r <= 1'b0;
            time_base_prescale_r <= `CIT_PRE_ZERO;
        end else if (wr_tsc) begin
            tb_enable_r <= reg_wdata[`CIT_TSC_EN_BIT];
            stamp_at_frame_end_r <= reg_wdata[`CIT_TSC_EOF_BIT];
            fd_stamp_after_fdf_r <= reg_wdata[`CIT_TSC_RES_BIT];
            time_base_prescale_r <= reg_wdata[`CIT_TSC_PRE_MSB:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_hi_r <= 8'h00;
            en_lo_r <= 5'h00;
        end else if (wr_int) begin
            en_hi_r <= reg_wdata[31:24];
            en_lo_r <= reg_wdata[20:16];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            invalid_msg_flag_r <= 1'b0;
            wake_flag_r <= 1'b0;
            bus_error_flag_r <= 1'b0;
            mab_cause_r <= 1'b0;
            addr_cause_r <= 1'b0;
            mode_change_flag_r <= 1'b0;
            time_base_wrap_flag_r <= 1'b0;
        end else begin
            invalid_msg_flag_r <= invalid_msg_flag_nxt;
            wake_flag_r <= wake_flag_nxt;
            bus_error_flag_r <= bus_error_flag_nxt;
            mab_cause_r <= mab_cause_nxt;
            addr_cause_r <= addr_cause_nxt;
            mode_change_flag_r <= mode_change_flag_nxt;
            time_base_wrap_flag_r <= time_base_wrap_flag_nxt;
        end
    end
    // Two causes kept apart so the code can tell them; one flag shows both
    assign system_error_flag_r = mab_cause_r | addr_cause_r;

    // Mode is only tracked after one clean sample, so reset never flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_prev_r <= 3'h0;
            mode_primed_r <= 1'b0;
        end else begin
            mode_prev_r <= operating_mode_status;
            mode_primed_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_match_number_r <= 5'h00;
        end else if (filter_match_evt) begin
            filter_match_number_r <= filter_match_in;
        end
    end

    // Stamp point selection; an FD frame overwrites its SOF stamp at the res bit
    wire logic stamp_end_pt = stamp_at_frame_end_r && (rx_frame_ok || tx_frame_ok);
    wire logic stamp_sof_pt = !stamp_at_frame_end_r && sof_sample;
    wire logic stamp_res_pt = !stamp_at_frame_end_r && fd_stamp_after_fdf_r
        && fdf_next_sample;
    wire logic stamp_now = stamp_end_pt || stamp_sof_pt || stamp_res_pt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stamp_value <= `CIT_ZERO32;
            stamp_strobe <= 1'b0;
        end else begin
            stamp_strobe <= stamp_now;
            if (stamp_now) begin
                stamp_value <= tb_link.count;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `CIT_ZERO32;
            irq_n <= 1'b1;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : reg_rdata;
            irq_n <= !any_enabled;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence wrap_clr_same_s;
        tb_link.wrap && wr_int && !reg_wdata[2];
    endsequence
    sequence wrap_flag_held_s;
        time_base_wrap_flag_r [*2];
    endsequence
    // Every stamp point ends the same way: strobe plus the count of the pulse edge
    sequence stamp_taken_s;
        stamp_strobe && stamp_value == $past(tb_link.count);
    endsequence

    wrap_set_wins_a: assert property (wrap_clr_same_s |=> wrap_flag_held_s)
        else $error("wrap flag lost to a same-cycle clear");
    sticky_clear_a: assert property (
        wr_int && !reg_wdata[2] && !tb_link.wrap |=> !time_base_wrap_flag_r)
        else $error("wrap flag survived a clear");
    flag_only_sw_a: assert property (
        invalid_msg_flag_r && !(wr_int && !reg_wdata[15]) |=> invalid_msg_flag_r)
        else $error("invalid message flag dropped without a clear");
    rx_code_idle_a: assert property (
        rx_fifo_pending_vector == `CIT_ZERO32 |-> receive_code == `CIT_CODE_NONE)
        else $error("receive code not idle with nothing pending");
    tx_queue_code_a: assert property (
        tx_fifo_pending_vector == 32'h0000_0001 |-> transmit_code == 7'h00)
        else $error("queue pending not coded as zero");
    mode_change_a: assert property (
        mode_primed_r && $changed(operating_mode_status) |=> mode_change_flag_r)
        else $error("mode change not flagged");
    mode_quiet_a: assert property (
        !mode_change_flag_r && $stable(operating_mode_status) |=> !mode_change_flag_r)
        else $error("mode change flag set without a mode change");
    irq_out_a: assert property (
        any_enabled |=> !irq_n ##1 (irq_n == !$past(any_enabled)))
        else $error("interrupt output does not follow enabled flags");
    irq_idle_a: assert property (!any_enabled |=> irq_n)
        else $error("interrupt output low with nothing enabled pending");
    stamp_end_a: assert property (
        stamp_at_frame_end_r && rx_frame_ok |=> stamp_taken_s)
        else $error("end-of-frame stamp missed");
    stamp_tx_end_a: assert property (
        stamp_at_frame_end_r && tx_frame_ok |=> stamp_taken_s)
        else $error("transmit end-of-frame stamp missed");
    stamp_quiet_a: assert property (
        stamp_at_frame_end_r && !rx_frame_ok && !tx_frame_ok |=> !stamp_strobe)
        else $error("stamp taken before the frame was valid");
    stamp_sof_a: assert property (
        !stamp_at_frame_end_r && sof_sample |=> stamp_taken_s)
        else $error("start-of-frame stamp missed");
    stamp_fd_a: assert property (
        !stamp_at_frame_end_r && fd_stamp_after_fdf_r && fdf_next_sample |=> stamp_taken_s)
        else $error("stamp after the FD format bit missed");
    global_top_a: assert property (
        tx_attempt_flag && tx_attempt_enable |-> global_irq_code == `CIT_CODE_TXAT)
        else $error("attempt code not reported first");
endmodule : cit_top

// *** hdl/cit_defs.svh ***
// Offsets, field positions, codes and reset values of the interrupt and time-base unit
`ifndef CIT_DEFS_SVH
`define CIT_DEFS_SVH
`define CIT_ADDR_TBC 8'h00
`define CIT_ADDR_TSC 8'h04
`define CIT_ADDR_VEC 8'h08
`define CIT_ADDR_INT 8'h0C
`define CIT_ADDR_RXV 8'h10
`define CIT_ADDR_TXV 8'h14
`define CIT_TSC_PRE_MSB 9
`define CIT_TSC_EN_BIT 16
`define CIT_TSC_EOF_BIT 17
`define CIT_TSC_RES_BIT 18
`define CIT_EN_SHIFT 16
`define CIT_CODE_NONE 7'h40
`define CIT_CODE_TXAT 7'h4A
`define CIT_CODE_TEF 7'h49
`define CIT_CODE_IVM 7'h48
`define CIT_CODE_MOD 7'h47
`define CIT_CODE_TBC 7'h46
`define CIT_CODE_MAB 7'h45
`define CIT_CODE_ADDR 7'h44
`define CIT_CODE_RXOV 7'h43
`define CIT_CODE_WAK 7'h42
`define CIT_CODE_CERR 7'h41
`define CIT_ZERO32 32'h0000_0000
`define CIT_ONES32 32'hFFFF_FFFF
`define CIT_PRE_ZERO 10'h000
`endif

// *** hdl/cit_pkg.sv ***
// Shared types and code-encoding function
`include "cit_defs.svh"
package cit_pkg;
    typedef logic [6:0] cit_code_type;
    typedef logic [9:0] cit_pre_type;

    // Highest set index wins; empty vector gives the no-interrupt code
    function automatic cit_code_type cit_high_code(input logic [31:0] v);
        cit_code_type c;
        c = `CIT_CODE_NONE;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                c = 7'(i);
            end
        end
        return c;
    endfunction : cit_high_code
endpackage : cit_pkg

// *** hdl/cit_tb_if.sv ***
// Link between the register core and the time base counter
`timescale 1ns/1ps
interface cit_tb_if;
    logic enable;
    cit_pkg::cit_pre_type prescale;
    logic load;
    logic [31:0] load_value;
    logic [31:0] count;
    logic wrap;
    modport core (output enable, output prescale, output load, output load_value,
                  input count, input wrap);
    modport tbase (input enable, input prescale, input load, input load_value,
                   output count, output wrap);
endinterface : cit_tb_if

// *** hdl/cit_tbase.sv ***
// Prescaled 32-bit free-running time base counter
`timescale 1ns/1ps
`include "cit_defs.svh"
module cit_tbase (
    input wire logic sys_clk,
    input wire logic rst_n,
    cit_tb_if.tbase tb
);
    cit_pkg::cit_pre_type pre_cnt_r;
    logic [31:0] count_r;
    logic wrap_r;
    // At or past the setting, so a lowered prescale never waits for a 10-bit wrap
    wire logic tick = (pre_cnt_r >= tb.prescale);
    wire logic at_top = (count_r == `CIT_ONES32);

    assign tb.count = count_r;
    assign tb.wrap = wrap_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_r <= `CIT_PRE_ZERO;
            count_r <= `CIT_ZERO32;
            wrap_r <= 1'b0;
        end else if (!tb.enable) begin
            pre_cnt_r <= `CIT_PRE_ZERO;
            count_r <= `CIT_ZERO32;
            wrap_r <= 1'b0;
        end else if (tb.load) begin
            pre_cnt_r <= `CIT_PRE_ZERO;
            count_r <= tb.load_value;
            wrap_r <= 1'b0;
        end else begin
            pre_cnt_r <= tick ? `CIT_PRE_ZERO : pre_cnt_r + 10'h001;
            count_r <= tick ? count_r + 32'h0000_0001 : count_r;
            wrap_r <= tick & at_top;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    tb_stop_zero_a: assert property (!tb.enable |=> count_r == `CIT_ZERO32)
        else $error("time base not zero while disabled");
    tb_every_clock_a: assert property (
        tb.enable && !tb.load && tb.prescale == `CIT_PRE_ZERO && $past(tb.enable)
        && !$past(tb.load) |=> count_r == $past(count_r) + 32'h0000_0001)
        else $error("time base missed a tick at prescale zero");
    tb_load_a: assert property (
        tb.enable && tb.load |=> count_r == $past(tb.load_value)
        && pre_cnt_r == `CIT_PRE_ZERO)
        else $error("counter write did not restart prescaler");
endmodule : cit_tbase

// *** tb/canfd_irq_timebase_bench.sv ***
// Self-checking bench for the interrupt code, flag and time base unit
`timescale 1ns/1ps
`include "cit_defs.svh"
module canfd_irq_timebase_bench;
    logic sys_clk, rst_n, reg_wr, reg_rd, stamp_strobe, irq_n;
    logic ivm, wak, berr, message_assembly_buffer, adr, spic, ramc, transmit_event_fifo, fme, sof, fdf, rxok, txok;
    logic [2:0] opm;
    logic [4:0] fmi;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, stamp_value, rxov, txat, rxf, rxe, txf, txe, v1, v2;
    int failures, num_checks;

    cit_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .invalid_msg_evt(ivm), .wake_evt(wak), .bus_error_evt(berr), .mab_error_evt(message_assembly_buffer),
        .addr_error_evt(adr), .operating_mode_status(opm), .rx_ovf_pending(rxov),
        .tx_attempt_pending(txat), .spi_check_pending(spic), .ram_correction_pending(ramc),
        .tef_pending(transmit_event_fifo), .rx_fifo_flags(rxf), .rx_fifo_enables(rxe), .tx_fifo_flags(txf),
        .tx_fifo_enables(txe), .filter_match_evt(fme), .filter_match_in(fmi),
        .sof_sample(sof), .fdf_next_sample(fdf), .rx_frame_ok(rxok), .tx_frame_ok(txok),
        .stamp_value(stamp_value), .stamp_strobe(stamp_strobe), .irq_n(irq_n));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        if (failures == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    // Sources 0..4 are pulses, 5 a mode step, the rest levels
    task automatic src(input int i, input logic v);
        case (i)
            0: ivm = v;
            1: wak = v;
            2: berr = v;
            3: message_assembly_buffer = v;
            4: adr = v;
            5: if (v) opm = opm + 3'h1;
            6: rxov[7] = v;
            7: txat[3] = v;
            8: transmit_event_fifo = v;
            9: spic = v;
            default: ramc = v;
        endcase
    endtask : src

    task automatic reset_values();
        rd(`CIT_ADDR_TSC, v1); check("tscon", v1, 32'h0000_0000);
        rd(`CIT_ADDR_VEC, v1); check("vec", v1, 32'h4040_0040);
        rd(`CIT_ADDR_RXV, v1); check("rxv", v1, 32'h0000_0000);
        wr(8'h18, 32'hFFFF_FFFF);
        rd(8'h18, v1); check("unmapped", v1, 32'h0000_0000);
        wr(`CIT_ADDR_TSC, 32'hFFFF_FFFF);
        rd(`CIT_ADDR_TSC, v1); check("tscon bits", v1, 32'h0007_03FF);
        wr(`CIT_ADDR_TSC, 32'h0000_0000);
        wr(`CIT_ADDR_INT, 32'hFFFF_FFFF);
        rd(`CIT_ADDR_INT, v1); check("int layout", v1, 32'hFF1F_0000);
        check("irq idle", 32'(irq_n), 32'h1);
    endtask : reset_values

    task automatic time_base();
        int pre[3] = '{0, 5, 1023};
        foreach (pre[k]) begin
            wr(`CIT_ADDR_TSC, 32'h0001_0000 | 32'(pre[k]));
            rd(`CIT_ADDR_TBC, v1);
            idle((pre[k] + 1) * 10 - 2);
            rd(`CIT_ADDR_TBC, v2);
            check("tick rate", v2 - v1, 32'h0000_000A);
        end
        wr(`CIT_ADDR_TSC, 32'h0001_0003);
        wr(`CIT_ADDR_TBC, 32'h0000_0000);
        idle(5);
        rd(`CIT_ADDR_TBC, v1);
        idle(1);
        wr(`CIT_ADDR_TBC, 32'h0000_0000);
        idle(5);
        rd(`CIT_ADDR_TBC, v2);
        check("prescale restart", v2, v1);
        rd(`CIT_ADDR_TSC, v1); check("prescale kept", v1, 32'h0001_0003);
        wr(`CIT_ADDR_TSC, 32'h0000_0000);
        rd(`CIT_ADDR_TBC, v1); check("stopped", v1, 32'h0000_0000);
        wr(`CIT_ADDR_TBC, 32'h0000_0037);
        rd(`CIT_ADDR_TBC, v1); check("held zero", v1, 32'h0000_0000);
        wr(`CIT_ADDR_TSC, 32'h0001_0000);
        wr(`CIT_ADDR_INT, 32'h0004_0000);
        wr(`CIT_ADDR_TBC, 32'hFFFF_FFF0);
        idle(15);
        // Clear lands on the wrap edge; the set must win
        wr(`CIT_ADDR_INT, 32'h0004_0000);
        idle(13);
        rd(`CIT_ADDR_INT, v1); check("wrap flag", v1, 32'h0004_0004);
        rd(`CIT_ADDR_VEC, v1); check("wrap code", v1 & 32'h7F, 32'h46);
        check("wrap irq", 32'(irq_n), 32'h0);
        idle(10);
        rd(`CIT_ADDR_INT, v1); check("wrap sticky", v1, 32'h0004_0004);
        wr(`CIT_ADDR_INT, 32'h0004_0000);
        wr(`CIT_ADDR_TSC, 32'h0000_0000);
        rd(`CIT_ADDR_INT, v1); check("wrap cleared", v1, 32'h0004_0000);
    endtask : time_base

    task automatic global_sources();
        logic [6:0] code[11] = '{7'h48, 7'h42, 7'h41, 7'h45, 7'h44, 7'h47, 7'h43, 7'h4A,
                                 7'h49, 7'h40, 7'h40};
        int fbit[11] = '{15, 14, 13, 12, 12, 3, 11, 10, 4, 9, 8};
        wr(`CIT_ADDR_INT, 32'hFF1F_0000);
        for (int i = 0; i < 11; i++) begin
            @(negedge sys_clk) src(i, 1'b1);
            @(negedge sys_clk) if (i < 6) src(i, 1'b0);
            idle(2);
            rd(`CIT_ADDR_INT, v1); check("flag", v1, 32'hFF1F_0000 | (32'h1 << fbit[i]));
            rd(`CIT_ADDR_VEC, v1); check("global code", v1 & 32'h7F, 32'(code[i]));
            check("irq raised", 32'(irq_n), 32'h0);
            if (i > 5) src(i, 1'b0);
            else wr(`CIT_ADDR_INT, 32'hFF1F_0000);
            idle(3);
            rd(`CIT_ADDR_INT, v1); check("flag gone", v1, 32'hFF1F_0000);
            check("irq released", 32'(irq_n), 32'h1);
        end
        @(negedge sys_clk) begin ivm = 1'b1; wak = 1'b1; berr = 1'b1; rxov[9] = 1'b1; end
        @(negedge sys_clk) begin ivm = 1'b0; wak = 1'b0; berr = 1'b0; end
        rd(`CIT_ADDR_VEC, v1); check("highest wins", v1 & 32'h7F, 32'h48);
        rxov[9] = 1'b0;
        wr(`CIT_ADDR_INT, 32'h0000_0000);
        src(1, 1'b1);
        @(negedge sys_clk) src(1, 1'b0);
        idle(3);
        check("masked irq", 32'(irq_n), 32'h1);
        rd(`CIT_ADDR_VEC, v1); check("masked code", v1 & 32'h7F, 32'h40);
        wr(`CIT_ADDR_INT, 32'h0000_0000);
    endtask : global_sources

    task automatic fifo_codes();
        wr(`CIT_ADDR_INT, 32'h0003_0000);
        @(negedge sys_clk) begin fme = 1'b1; fmi = 5'h1F; end
        @(negedge sys_clk) begin fme = 1'b0; fmi = 5'h00; end
        rxf = 32'h0010_0021;
        rxe = 32'hFFEF_FFFF;
        txf = 32'h0000_0001;
        idle(3);
        rd(`CIT_ADDR_RXV, v1); check("rx pending", v1, 32'h0000_0020);
        rd(`CIT_ADDR_TXV, v1); check("tx pending", v1, 32'h0000_0001);
        rd(`CIT_ADDR_VEC, v1); check("vec fifo", v1, 32'h0500_1F05);
        rd(`CIT_ADDR_INT, v1); check("summaries", v1, 32'h0003_0003);
        rxf = 32'h0000_0000;
        txf = 32'h8000_0001;
        idle(3);
        rd(`CIT_ADDR_VEC, v1); check("vec tx high", v1, 32'h401F_1F1F);
        txf = 32'h0000_0000;
        idle(3);
        rd(`CIT_ADDR_VEC, v1); check("vec idle", v1, 32'h4040_1F40);
        rd(`CIT_ADDR_INT, v1); check("summaries off", v1, 32'h0003_0000);
        check("irq off", 32'(irq_n), 32'h1);
    endtask : fifo_codes

    task automatic stamps();
        logic [31:0] mode[3] = '{32'h0003_0000, 32'h0001_0000, 32'h0005_0000};
        logic [3:0] hit[3] = '{4'b1100, 4'b0001, 4'b0011};
        for (int m = 0; m < 3; m++) begin
            wr(`CIT_ADDR_TSC, mode[m]);
            for (int k = 0; k < 4; k++) begin
                @(negedge sys_clk) begin reg_rd = 1'b1; reg_addr = `CIT_ADDR_TBC; end
                {txok, rxok, fdf, sof} = 4'b0001 << k;
                @(negedge sys_clk) begin reg_rd = 1'b0; {txok, rxok, fdf, sof} = 4'h0; end
                check("stamp strobe", 32'(stamp_strobe), 32'(hit[m][k]));
                if (hit[m][k]) check("stamp value", stamp_value, reg_rdata);
                idle(1);
                check("strobe ends", 32'(stamp_strobe), 32'h0);
            end
        end
    endtask : stamps

    initial begin
        {rst_n, reg_wr, reg_rd, ivm, wak, berr, message_assembly_buffer, adr, spic, ramc, transmit_event_fifo, fme} = '0;
        {sof, fdf, rxok, txok, opm, fmi, reg_addr, reg_wdata} = '0;
        {rxov, txat, rxf, txf} = '0;
        rxe = 32'hFFFF_FFFF;
        txe = 32'hFFFF_FFFF;
        failures = 0;
        num_checks = 0;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        reset_values();
        time_base();
        global_sources();
        fifo_codes();
        stamps();
        print_verdict();
    end

    // Run needs about 11k cycles; the margin covers slow handshakes
    initial begin
        #200_000;
        failures++;
        print_verdict();
    end
endmodule : canfd_irq_timebase_bench
